// ===== isrs_pkg.sv
// constants, field positions and state codes of the readout sequencer
package isrs_pkg;
	// ------------------------------------------------------------
	// register addresses (word bits 15:12)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_SEQ       = 4'h0;
	localparam logic [3:0] ADDR_PIXELS    = 4'h1;
	localparam logic [3:0] ADDR_LINES     = 4'h2;
	localparam logic [3:0] ADDR_EXPOSURE  = 4'h3;
	localparam logic [3:0] ADDR_COL_START = 4'h4;
	localparam logic [3:0] ADDR_READ_ROW  = 4'h5;
	localparam logic [3:0] ADDR_RESET_ROW = 4'h6;
	localparam logic [3:0] ADDR_CORE      = 4'h7;
	localparam logic [3:0] ADDR_AMP       = 4'h8;
	localparam int WORD_ADDR_LSB = 12;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SEQ_SHUTTER     = 0;
	localparam int SEQ_COL_DIV_LSB = 4;
	localparam int SEQ_SS_DIV_LSB  = 6;
	localparam int SEQ_KNEE_LSB    = 8;
	localparam int SEQ_KNEE_EN     = 10;
	localparam int SEQ_EXT_RESET   = 11;
	localparam int CORE_TEST_EVEN  = 0;
	localparam int CORE_TEST_ODD   = 1;
	localparam int CORE_XSUB_LSB   = 2;
	localparam int CORE_YSUB_LSB   = 5;
	localparam int AMP_GAIN_LSB    = 0;
	localparam int AMP_UNITY       = 4;
	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [11:0] RST_SEQ       = 12'h000;
	localparam logic [11:0] RST_PIXELS    = 12'h27F;
	localparam logic [11:0] RST_LINES     = 12'h1FF;
	localparam logic [11:0] RST_EXPOSURE  = 12'h3FF;
	localparam logic [10:0] RST_COL_START = 11'h000;
	localparam logic [10:0] RST_ROW_START = 11'h000;
	localparam logic [7:0]  RST_CORE      = 8'h00;
	localparam logic [6:0]  RST_AMP       = 7'h50;
	// ------------------------------------------------------------
	// dividers and row space
	// ------------------------------------------------------------
	localparam int          DIV_W        = 9;
	localparam logic [8:0]  SS_DIV_BASE  = 9'h020;
	localparam logic [8:0]  COL_DIV_BASE = 9'h004;
	localparam logic [10:0] ROW_LAST     = 11'h3FF;
	localparam int          PIN_STAGES   = 3;
	// snapshot sequencer states
	typedef enum logic [1:0] {
		ISRS_SS_IDLE  = 2'b00,
		ISRS_SS_HOLD  = 2'b01,
		ISRS_SS_COUNT = 2'b10,
		ISRS_SS_TOUT  = 2'b11
	} isrs_ss_state_t;
endpackage

// ===== isrs_pin_sync.sv
// three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module isrs_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// pin side and clean side
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} isrs_sync_t;

	isrs_sync_t q;
	isrs_sync_t next_q;

	// shift chain; first stage feeds only the second
	always_comb
	begin
		next_q    = q;
		next_q.s1 = pin;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		for (int i = 0; i < W; i++)
		begin
			if (q.s2[i] == q.s3[i])
				next_q.out[i] = q.s3[i];
		end
	end

	// state register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign level = q.out;
endmodule

// ===== isrs_divider.sv
// selectable clock-enable divider: base times 1, 2, 4 or 8
`timescale 1ns/1ps
module isrs_divider #(
	parameter logic [isrs_pkg::DIV_W-1:0] BASE = isrs_pkg::SS_DIV_BASE
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// control
	input  wire logic [1:0] sel,
	input  wire logic       restart,
	// one-cycle enable
	output logic            tick
);
	typedef struct packed {
		logic [isrs_pkg::DIV_W-1:0] cnt;
	} isrs_div_t;

	isrs_div_t                  q;
	isrs_div_t                  next_q;
	logic [isrs_pkg::DIV_W-1:0] last;

	// restart aligns the first tick to the caller's event
	always_comb
	begin
		last   = isrs_pkg::DIV_W'((BASE << sel) - 1'b1);
		next_q = q;
		if (restart || q.cnt == last)
			next_q.cnt = '0;
		else
			next_q.cnt = q.cnt + 1'b1;
	end

	// state register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign tick = (q.cnt == last) && !restart;
endmodule

// ===== isrs_top.sv
// readout sequencer: register file, shutter timers, row pointers and readout markers
`timescale 1ns/1ps
// What this block does
// RL1 - snapshot clock: system clock / 32..256
// RL2 - column clock: system clock / 4..32
// RL3 - knee enable selects right reset path
// RL4 - rolling shutter: controller uses knee select only
// RL5 - external level bit disables reset generator
// RL6 - row readout sync raises pixel valid
// RL7 - pixel valid drops at pixels per row
// RL8 - line counter gives last line pulse
// RL9 - global timer counts to exposure length
// RL10 - controller may time long exposures itself
// RL11 - exposure length never below ten; not enforced here, any written value is stored
// RL12 - frame start loads read pointer, sync
// RL13 - row clock advances; match loads reset pointer
// RL14 - read sync clears integration counter
// RL15 - pointers advance until next reload
// RL16 - exposure lines = lines minus exposure
// RL17 - column start picks pixel pair position
// RL18 - row starts select one of 1024
// RL19 - test bits tie even/odd columns
// RL20 - sub-sampling modes from core bits
// RL21 - unity bit bypasses amplifier gain
// RL22 - shutter bit: 0 global, 1 rolling
// RL23 - time-out high one snapshot period
// RL24 - 16-bit write word: address, data
// RL25 - controller updates registers between frames
module isrs_top (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// register write port (pins)
	input  wire logic [15:0] reg_word,
	input  wire logic        reg_write,
	// sequencer strobes (pins)
	input  wire logic        frame_start,
	input  wire logic        row_clock,
	input  wire logic        snapshot_start,
	input  wire logic        snapshot_stop,
	// readout markers
	output logic             pixel_valid,
	output logic             last_line,
	output logic             time_out,
	// row pointers
	output logic             read_pointer_sync,
	output logic             reset_pointer_sync,
	output logic      [10:0] read_pointer,
	output logic      [10:0] reset_pointer,
	// array and amplifier controls
	output logic             rolling_shutter,
	output logic             right_reset_path,
	output logic      [1:0]  knee_select,
	output logic             reset_gen_enable,
	output logic             test_even_tie,
	output logic             test_odd_tie,
	output logic      [2:0]  x_subsample_mode,
	output logic      [2:0]  y_subsample_mode,
	output logic      [10:0] column_start_pos,
	output logic      [3:0]  amp_gain,
	output logic             amp_unity,
	output logic      [11:0] exposure_lines
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [11:0]             seq;
		logic [11:0]             ppr;
		logic [11:0]             lpf;
		logic [11:0]             exp_len;
		logic [10:0]             col;
		logic [10:0]             rd_start;
		logic [10:0]             rs_start;
		logic [7:0]              core;
		logic [6:0]              amp;
		logic [4:0]              prev;
		isrs_pkg::isrs_ss_state_t ss;
		logic [11:0]             ss_cnt;
		logic                    tout;
		logic                    blank_pend;
		logic                    pv;
		logic [11:0]             pix_cnt;
		logic                    line_armed;
		logic [11:0]             line_cnt;
		logic                    last;
		logic                    rd_sync;
		logic                    rs_sync;
		logic [10:0]             rd_ptr;
		logic [10:0]             rs_ptr;
		logic [11:0]             integ_cnt;
		logic                    o_roll;
		logic                    o_right;
		logic [1:0]              o_knee;
		logic                    o_gen;
		logic                    o_teven;
		logic                    o_todd;
		logic [2:0]              o_xsub;
		logic [2:0]              o_ysub;
		logic [3:0]              o_gain;
		logic                    o_unity;
		logic [11:0]             o_explines;
	} isrs_state_t;

	isrs_state_t q;
	isrs_state_t next_q;
	logic [20:0] lvl;
	logic        wr_edge;
	logic        fs_edge;
	logic        rc_edge;
	logic        ssa_edge;
	logic        ssp_edge;
	logic        ss_tick;
	logic        col_tick;
	logic        ss_restart;
	logic        x_sync;

	// ------------------------------------------------------------
	// pin synchronisers and dividers
	// ------------------------------------------------------------
	isrs_pin_sync #(
		.W (21)
	) u_sync (
		.clock (clock),
		.rst   (rst),
		.pin   ({reg_write, frame_start, row_clock, snapshot_start, snapshot_stop, reg_word}),
		.level (lvl)
	);

	// RL1 snapshot clock divide
	isrs_divider #(
		.BASE (isrs_pkg::SS_DIV_BASE)
	) u_ss_div (
		.clock   (clock),
		.rst     (rst),
		.sel     (q.seq[isrs_pkg::SEQ_SS_DIV_LSB +: 2]),
		.restart (ss_restart),
		.tick    (ss_tick)
	);

	// RL2 column clock divide, restarted by each row clock
	isrs_divider #(
		.BASE (isrs_pkg::COL_DIV_BASE)
	) u_col_div (
		.clock   (clock),
		.rst     (rst),
		.sel     (q.seq[isrs_pkg::SEQ_COL_DIV_LSB +: 2]),
		.restart (rc_edge),
		.tick    (col_tick)
	);

	// rising edges of the agreed pin levels
	assign wr_edge    = lvl[20] && !q.prev[4];
	assign fs_edge    = lvl[19] && !q.prev[3];
	assign rc_edge    = lvl[18] && !q.prev[2];
	assign ssa_edge   = lvl[17] && !q.prev[1];
	assign ssp_edge   = lvl[16] && !q.prev[0];
	// a start while the timer runs is refused, so the divider keeps its phase
	assign ss_restart = ssa_edge && !q.seq[isrs_pkg::SEQ_SHUTTER] && q.ss == isrs_pkg::ISRS_SS_IDLE;
	assign x_sync     = col_tick && q.blank_pend;

	// row pointer step with wrap over the row space
	function automatic logic [10:0] isrs_next_row(input logic [10:0] p);
		isrs_next_row = (p == isrs_pkg::ROW_LAST) ? 11'h000 : 11'(p + 1'b1);
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_q         = q;
		next_q.prev    = lvl[20:16];
		next_q.rd_sync = 1'b0;
		next_q.rs_sync = 1'b0;
		next_q.last    = 1'b0;
		// RL24 word decode on write strobe; unlisted addresses ignored
		if (wr_edge)
		begin
			case (lvl[15:isrs_pkg::WORD_ADDR_LSB])
				isrs_pkg::ADDR_SEQ:       next_q.seq      = lvl[11:0];
				isrs_pkg::ADDR_PIXELS:    next_q.ppr      = lvl[11:0];
				isrs_pkg::ADDR_LINES:     next_q.lpf      = lvl[11:0];
				isrs_pkg::ADDR_EXPOSURE:  next_q.exp_len  = lvl[11:0];
				// RL17 column start stored as written
				isrs_pkg::ADDR_COL_START: next_q.col      = lvl[10:0];
				// RL18 read and reset row starts
				isrs_pkg::ADDR_READ_ROW:  next_q.rd_start = lvl[10:0];
				isrs_pkg::ADDR_RESET_ROW: next_q.rs_start = lvl[10:0];
				isrs_pkg::ADDR_CORE:      next_q.core     = lvl[7:0];
				isrs_pkg::ADDR_AMP:       next_q.amp      = lvl[6:0];
				default:                  next_q.core     = q.core;
			endcase
		end
		// RL9 global shutter timer; stop strobe aborts it
		case (q.ss)
			isrs_pkg::ISRS_SS_IDLE:
				if (ss_restart)
					next_q.ss = isrs_pkg::ISRS_SS_HOLD;
			isrs_pkg::ISRS_SS_HOLD:
				if (!lvl[17])
				begin
					next_q.ss     = isrs_pkg::ISRS_SS_COUNT;
					next_q.ss_cnt = 12'h000;
				end
			isrs_pkg::ISRS_SS_COUNT:
				if (ssp_edge)
					next_q.ss = isrs_pkg::ISRS_SS_IDLE;
				else if (ss_tick && q.ss_cnt == q.exp_len)
				begin
					next_q.ss   = isrs_pkg::ISRS_SS_TOUT;
					next_q.tout = 1'b1;
				end
				else if (ss_tick)
					next_q.ss_cnt = q.ss_cnt + 1'b1;
			isrs_pkg::ISRS_SS_TOUT:
				// RL23 one snapshot period high
				if (ss_tick)
				begin
					next_q.ss   = isrs_pkg::ISRS_SS_IDLE;
					next_q.tout = 1'b0;
				end
			default:
			begin
				next_q.ss   = isrs_pkg::ISRS_SS_IDLE;
				next_q.tout = 1'b0;
			end
		endcase
		// RL6 row blanking then readout sync raises valid
		if (rc_edge)
			next_q.blank_pend = 1'b1;
		else if (x_sync)
		begin
			next_q.blank_pend = 1'b0;
			next_q.pv         = 1'b1;
			next_q.pix_cnt    = 12'h000;
		end
		// RL7 one pixel pair per clock until the count
		else if (q.pv)
		begin
			if (q.pix_cnt == q.ppr)
				next_q.pv = 1'b0;
			else
				next_q.pix_cnt = q.pix_cnt + 1'b1;
		end
		// RL8 line counting and last line
		if (fs_edge)
		begin
			next_q.line_armed = 1'b1;
			next_q.line_cnt   = 12'h000;
		end
		else if (rc_edge && q.line_armed)
		begin
			if (q.line_cnt == q.lpf)
			begin
				next_q.last       = 1'b1;
				next_q.line_armed = 1'b0;
			end
			else
				next_q.line_cnt = q.line_cnt + 1'b1;
		end
		// RL15 pointers keep moving between reloads
		if (rc_edge)
		begin
			next_q.rd_ptr    = isrs_next_row(q.rd_ptr);
			next_q.rs_ptr    = isrs_next_row(q.rs_ptr);
			next_q.integ_cnt = q.integ_cnt + 1'b1;
			// RL13 counter match reloads reset pointer
			if (q.seq[isrs_pkg::SEQ_SHUTTER] && 12'(q.integ_cnt + 1'b1) == q.exp_len)
			begin
				next_q.rs_sync = 1'b1;
				next_q.rs_ptr  = q.rs_start;
			end
		end
		// RL12 frame start reloads read pointer
		if (fs_edge && q.seq[isrs_pkg::SEQ_SHUTTER])
		begin
			next_q.rd_sync = 1'b1;
			next_q.rd_ptr  = q.rd_start;
			// RL14 read sync clears integration count
			next_q.integ_cnt = 12'h000;
		end
		// RL22 shutter type
		next_q.o_roll = next_q.seq[isrs_pkg::SEQ_SHUTTER];
		// RL3 knee path and level
		next_q.o_right = next_q.seq[isrs_pkg::SEQ_KNEE_EN];
		next_q.o_knee  = next_q.seq[isrs_pkg::SEQ_KNEE_LSB +: 2];
		// RL5 internal generator off with external level
		next_q.o_gen = !next_q.seq[isrs_pkg::SEQ_EXT_RESET];
		// RL19 column test ties
		next_q.o_teven = next_q.core[isrs_pkg::CORE_TEST_EVEN];
		next_q.o_todd  = next_q.core[isrs_pkg::CORE_TEST_ODD];
		// RL20 sub-sampling fields
		next_q.o_xsub = next_q.core[isrs_pkg::CORE_XSUB_LSB +: 3];
		next_q.o_ysub = next_q.core[isrs_pkg::CORE_YSUB_LSB +: 3];
		// RL21 gain only when not in unity feedback
		next_q.o_unity = next_q.amp[isrs_pkg::AMP_UNITY];
		next_q.o_gain  = next_q.o_unity ? 4'h0 : next_q.amp[isrs_pkg::AMP_GAIN_LSB +: 4];
		// RL16 rolling exposure in lines
		next_q.o_explines = 12'(next_q.lpf - next_q.exp_len);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			q            <= '0;
			q.seq        <= isrs_pkg::RST_SEQ;
			q.ppr        <= isrs_pkg::RST_PIXELS;
			q.lpf        <= isrs_pkg::RST_LINES;
			q.exp_len    <= isrs_pkg::RST_EXPOSURE;
			q.col        <= isrs_pkg::RST_COL_START;
			q.rd_start   <= isrs_pkg::RST_ROW_START;
			q.rs_start   <= isrs_pkg::RST_ROW_START;
			q.core       <= isrs_pkg::RST_CORE;
			q.amp        <= isrs_pkg::RST_AMP;
			q.ss         <= isrs_pkg::ISRS_SS_IDLE;
			q.o_gen      <= 1'b1;
			q.o_unity    <= 1'b1;
			q.o_explines <= 12'(isrs_pkg::RST_LINES - isrs_pkg::RST_EXPOSURE);
		end
		else
			q <= next_q;
	end

	// outputs straight from the state register
	assign pixel_valid        = q.pv;
	assign last_line          = q.last;
	assign time_out           = q.tout;
	assign read_pointer_sync  = q.rd_sync;
	assign reset_pointer_sync = q.rs_sync;
	assign read_pointer       = q.rd_ptr;
	assign reset_pointer      = q.rs_ptr;
	assign rolling_shutter    = q.o_roll;
	assign right_reset_path   = q.o_right;
	assign knee_select        = q.o_knee;
	assign reset_gen_enable   = q.o_gen;
	assign test_even_tie      = q.o_teven;
	assign test_odd_tie       = q.o_todd;
	assign x_subsample_mode   = q.o_xsub;
	assign y_subsample_mode   = q.o_ysub;
	assign column_start_pos   = q.col;
	assign amp_gain           = q.o_gain;
	assign amp_unity          = q.o_unity;
	assign exposure_lines     = q.o_explines;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	localparam int X_MAX = 33;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_SS_DIV: assert property (ss_restart && q.seq[7:6] == 2'b00 |-> ##32 ss_tick) // RL1
		else $error("snapshot tick not 32 cycles after restart");
	AST_COL_DIV: assert property (rc_edge && q.seq[5:4] == 2'b00 |-> ##4 col_tick) // RL2
		else $error("column tick not 4 cycles after row clock");
	AST_KNEE: assert property (right_reset_path == q.seq[10] && knee_select == q.seq[9:8]) // RL3
		else $error("knee outputs differ from config");
	AST_GEN: assert property (reset_gen_enable != q.seq[11]) // RL5
		else $error("reset generator enable wrong");
	AST_PV_RISE: assert property (rc_edge ##1 !rc_edge [*2] |-> ##[1:X_MAX] pixel_valid) // RL6
		else $error("pixel valid missing after row clock");
	AST_PV_FALL: assert property (pixel_valid && q.pix_cnt == q.ppr && !x_sync |=> !pixel_valid) // RL7
		else $error("pixel valid not dropped at count");
	AST_LAST: assert property (last_line |-> $past(rc_edge) && $past(q.line_cnt) == $past(q.lpf)) // RL8
		else $error("last line without matching count");
	AST_TOUT: assert property ($rose(time_out) |-> $past(q.ss_cnt) == q.exp_len && $past(ss_tick)) // RL9
		else $error("time-out at wrong count");
	AST_TOUT_LEN: assert property (time_out && !ss_tick |=> time_out) // RL23
		else $error("time-out dropped before snapshot tick");
	AST_RD_SYNC: assert property (read_pointer_sync |-> read_pointer == q.rd_start && q.integ_cnt == 12'h000) // RL12
		else $error("read sync without reload or clear");
	AST_RS_SYNC: assert property (reset_pointer_sync |-> reset_pointer == q.rs_start && q.integ_cnt == q.exp_len) // RL13
		else $error("reset sync without reload at match");
	AST_GAIN: assert property (amp_unity |-> amp_gain == 4'h0) // RL21
		else $error("gain applied in unity mode");
	AST_EXPL: assert property (##1 exposure_lines == 12'(q.lpf - q.exp_len)) // RL16
		else $error("exposure lines wrong");
endmodule

// ===== isrs_ctrl_model.sv
// controller model: register writes and sequencer strobes toward the sensor
`timescale 1ns/1ps
module isrs_ctrl_model (
	// clock
	input  wire logic        clock,
	// pins toward the sensor
	output logic      [15:0] reg_word,
	output logic             reg_write,
	output logic      [3:0]  strobe
);
	// strobe bits: 0 frame start, 1 row clock, 2 snapshot start, 3 snapshot stop
	initial
	begin
		reg_word = 16'h0000;
		reg_write = 1'b0;
		strobe = 4'h0;
	end

	// word settles well before the strobe, since both pass the pin sync
	// address then data
	task automatic write_reg(input logic [3:0] a, input logic [11:0] d);
		@(posedge clock) reg_word <= {a, d};
		repeat (4) @(posedge clock);
		reg_write <= 1'b1;
		repeat (4) @(posedge clock);
		reg_write <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	// strobes held four cycles so the sync sees a clean level
	// stop driven by us
	task automatic pulse(input int s, input int gap);
		@(posedge clock) strobe[s] <= 1'b1;
		repeat (4) @(posedge clock);
		strobe[s] <= 1'b0;
		repeat (gap) @(posedge clock);
	endtask
endmodule

// ===== tb.sv
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] reg_word;
	logic        reg_write;
	logic [3:0]  strobe;
	logic        pixel_valid, last_line, time_out, read_pointer_sync, reset_pointer_sync;
	logic [10:0] read_pointer, reset_pointer, column_start_pos;
	logic        rolling_shutter, right_reset_path, reset_gen_enable, amp_unity;
	logic        test_even_tie, test_odd_tie;
	logic [1:0]  knee_select;
	logic [2:0]  x_subsample_mode, y_subsample_mode;
	logic [3:0]  amp_gain;
	logic [11:0] exposure_lines;
	logic [11:0] seq, core, amp, col, lines, expo, pix;
	logic [11:0] exp_q[6][$];
	logic [10:0] row0;
	logic        rc_d = 1'b0;
	logic        ss_d = 1'b0;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          seed = 11;
	int          cyc = 0;
	int          rows = 0;
	int          rw_wait = 0;
	int          to_wait = 0;
	int          pv_len = 0;
	int          to_len = 0;

	always #2 clock = ~clock;

	isrs_ctrl_model ctrl_u (.clock, .reg_word, .reg_write, .strobe);

	isrs_top dut_u (
		.clock, .rst, .reg_word, .reg_write,
		.frame_start(strobe[0]), .row_clock(strobe[1]),
		.snapshot_start(strobe[2]), .snapshot_stop(strobe[3]),
		.pixel_valid, .last_line, .time_out, .read_pointer_sync, .reset_pointer_sync,
		.read_pointer, .reset_pointer, .rolling_shutter, .right_reset_path, .knee_select,
		.reset_gen_enable, .test_even_tie, .test_odd_tie, .x_subsample_mode,
		.y_subsample_mode, .column_start_pos, .amp_gain, .amp_unity, .exposure_lines
	);

	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		n_checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// an event with no note pending must never match
	function automatic logic [11:0] pop(input int k);
		return exp_q[k].size() ? exp_q[k].pop_front() : 12'hXXX;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// bench copy of the register file except the two row starts, updated once each write task has finished
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		ctrl_u.write_reg(a, d);
		case (a)
			isrs_pkg::ADDR_SEQ: seq = d;
			isrs_pkg::ADDR_PIXELS: pix = d;
			isrs_pkg::ADDR_LINES: lines = d;
			isrs_pkg::ADDR_EXPOSURE: expo = d;
			isrs_pkg::ADDR_COL_START: col = d;
			isrs_pkg::ADDR_CORE: core = d;
			isrs_pkg::ADDR_AMP: amp = d;
			default: ;
		endcase
	endtask

	task automatic check_cfg();
		check(rolling_shutter, seq[0]);
		check({right_reset_path, knee_select}, seq[10:8]);
		check(reset_gen_enable, !seq[11]);
		check({test_odd_tie, test_even_tie}, core[1:0]);
		check({y_subsample_mode, x_subsample_mode}, core[7:2]);
		check({amp_unity, amp_gain}, amp[4] ? 12'h010 : amp[4:0]);
		check(column_start_pos, col);
		check(exposure_lines, lines - expo);
	endtask

	// every row clock also yields one pixel-valid run
	task automatic row();
		exp_q[4].push_back(pix + 12'h001);
		ctrl_u.pulse(1, 60);
	endtask

	// ------------------------------------------------------------
	// output watcher, samples settled values of the previous cycle
	// ------------------------------------------------------------
	always @(posedge clock)
	begin
		if (strobe[0])
			rows = 0;
		if (strobe[1] && !rc_d)
		begin
			rows++;
			rw_wait = 0;
		end
		else
			rw_wait++;
		rc_d = strobe[1];
		if (strobe[2] && !ss_d)
			to_wait = 0;
		else
			to_wait++;
		ss_d = strobe[2];
		if (read_pointer_sync)
			check(read_pointer, pop(0));
		if (reset_pointer_sync)
		begin
			check(reset_pointer, pop(1));
			check(read_pointer, pop(2));
		end
		if (last_line)
			check(rows, pop(3));
		if (pixel_valid && pv_len == 0)
			check(rw_wait >= (4 << seq[5:4]) + 2 && rw_wait <= (4 << seq[5:4]) + 6, 1'b1);
		if (pixel_valid)
			pv_len++;
		else if (pv_len != 0)
		begin
			check(pv_len, pop(4));
			pv_len = 0;
		end
		if (time_out && to_len == 0)
			check(to_wait >= expo * (32 << seq[7:6]) && to_wait <= (expo + 2) * (32 << seq[7:6]) + 20, 1'b1);
		if (time_out)
			to_len++;
		else if (to_len != 0)
		begin
			check(to_len, pop(5));
			to_len = 0;
		end
	end

	// hang guard, far above the expected run length
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seq = isrs_pkg::RST_SEQ;
		pix = isrs_pkg::RST_PIXELS;
		lines = isrs_pkg::RST_LINES;
		expo = isrs_pkg::RST_EXPOSURE;
		col = 12'h000;
		core = 12'h000;
		amp = {5'h00, isrs_pkg::RST_AMP};
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check_cfg();
		// random settings, global shutter kept; address 9 must be ignored
		for (int i = 0; i < 4; i++)
		begin
			wr(isrs_pkg::ADDR_SEQ, 12'($random(seed)) & 12'hFF0);
			wr(isrs_pkg::ADDR_CORE, 12'($random(seed)) & 12'h0FF);
			wr(isrs_pkg::ADDR_AMP, 12'($random(seed)) & 12'h07F);
			wr(isrs_pkg::ADDR_COL_START, 12'($random(seed)) & 12'h1FE);
			wr(isrs_pkg::ADDR_LINES, 12'($random(seed)));
			wr(isrs_pkg::ADDR_EXPOSURE, 12'h00A + (12'($random(seed)) & 12'h7FF));
			wr(4'h9, 12'($random(seed)));
			check_cfg();
		end
		// pixel runs at every column divide, no frame yet so no last line
		for (int c = 0; c < 4; c++)
		begin
			wr(isrs_pkg::ADDR_SEQ, 12'(c << 4));
			wr(isrs_pkg::ADDR_PIXELS, 12'h003 + (12'($random(seed)) & 12'h00F));
			row();
		end
		// four lines: one last-line pulse, then disarmed
		wr(isrs_pkg::ADDR_LINES, 12'h003);
		exp_q[3].push_back(12'h004);
		ctrl_u.pulse(0, 20);
		repeat (6) row();
		// rolling: equal row starts near the top so pointers wrap
		// row start inside the 1024-row space
		row0 = (11'($random(seed)) | 11'h3F8) & 11'h3FF;
		// knee enable left clear while rolling
		wr(isrs_pkg::ADDR_SEQ, 12'h001);
		wr(isrs_pkg::ADDR_LINES, 12'h1FF);
		wr(isrs_pkg::ADDR_EXPOSURE, 12'h00A);
		wr(isrs_pkg::ADDR_READ_ROW, {1'b0, row0});
		wr(isrs_pkg::ADDR_RESET_ROW, {1'b0, row0});
		check_cfg();
		exp_q[0].push_back({1'b0, row0});
		exp_q[0].push_back({1'b0, row0});
		exp_q[1].push_back({1'b0, row0});
		exp_q[2].push_back({1'b0, row0 + 11'h00A} & 12'h3FF);
		ctrl_u.pulse(0, 20);
		repeat (5) row();
		// second frame start must clear the exposure count
		ctrl_u.pulse(0, 20);
		repeat (10) row();
		// snapshot start has no effect while rolling
		ctrl_u.pulse(2, 400);
		// global timer at each snapshot divide
		for (int c = 0; c < 4; c++)
		begin
			wr(isrs_pkg::ADDR_SEQ, 12'(c << 6));
			exp_q[5].push_back(12'(32 << c));
			ctrl_u.pulse(2, 13 * (32 << c));
		end
		// stop while counting aborts without a time-out
		ctrl_u.pulse(2, 3 * 256);
		ctrl_u.pulse(3, 14 * 256);
		for (int k = 0; k < 6; k++)
			check(exp_q[k].size(), 12'h000);
		stop_test();
	end
endmodule
